// ===== design/cps_params.svh
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define CPS_CLK_MHZ 200
`define CPS_T_INTERNAL_REGULATOR_MS 220
`define CPS_T_QUAL_MS 30
`define CPS_T_RETRY_MS 2000
`define CPS_INTERNAL_REGULATOR_CYC (`CPS_T_INTERNAL_REGULATOR_MS * 1000 * `CPS_CLK_MHZ)
`define CPS_QUAL_CYC (`CPS_T_QUAL_MS * 1000 * `CPS_CLK_MHZ)
`define CPS_RETRY_CYC (`CPS_T_RETRY_MS * 1000 * `CPS_CLK_MHZ)

// ****************************************
// Register offsets
// ****************************************
`define CPS_OFS_CTRL 8'h00
`define CPS_OFS_ILIM 8'h04
`define CPS_OFS_STAT 8'h08

// ****************************************
// Control fields and reset values
// ****************************************
`define CPS_CTRL_FORCE 0
`define CPS_CTRL_HOST 1
`define CPS_CTRL_DP_LO 2
`define CPS_CTRL_DM_LO 4
`define CPS_DRV_HIZ 2'h0
`define CPS_ILIM_RST 5'h05

// ****************************************
// Current limit codes, 100 mA per step
// ****************************************
`define CPS_ILIM_500MA 5'h05
`define CPS_ILIM_1A 5'h0a
`define CPS_ILIM_2A 5'h14
`define CPS_ILIM_2A1 5'h15
`define CPS_ILIM_2A4 5'h18

// ****************************************
// Source type codes
// ****************************************
`define CPS_SRC_NONE 3'h0
`define CPS_SRC_SDP 3'h1
`define CPS_SRC_DCP 3'h3
`define CPS_SRC_UNKNOWN 3'h5
`define CPS_SRC_NSTD 3'h6

`endif

// ===== design/cps_pkg.sv
package cps_pkg;
    typedef enum logic [2:0] {
        ST_HIZ = 3'h0,
        ST_QUAL = 3'h1,
        ST_RETRY = 3'h2,
        ST_DETECT = 3'h3,
        ST_NSTD = 3'h4,
        ST_VLIM = 3'h5,
        ST_RUN = 3'h6
    } cps_state_t;
endpackage

// ===== design/cps_sequencer.sv
`timescale 1ns/1ps
`include "cps_params.svh"
// What this block does
// [R01] Supply above UVLO releases reset, registers default
// [R02] Battery only: battery switch on, regulator off
// [R03] Supplement overcurrent opens switch, sets disable bit
// [R04] Switch stays off until attach or ship exit
// [R05] Attach sequence: regulator, qualify, detect, limit, run
// [R06] Current limit loaded before converter starts
// [R07] Regulator on after 220 ms stable conditions
// [R08] High impedance: blocking, regulator, converter off
// [R09] Sleep condition stops converter switching
// [R10] Qualify: no overvoltage, above minimum 30 ms
// [R11] Failed qualification retried every two seconds
// [R12] Pass sets input good and pulses interrupt
// [R13] Detection only with regulator on, input good
// [R14] Detection done: irq, limit, power good, type
// [R15] BC1.2 first, DCD timeout goes non-standard
// [R16] SDP or unknown 500 mA, DCP 2.4 A
// [R17] Divider windows give 2.1, 2, 1, 2.4 A
// [R18] Current limit follows host writable field
// [R19] Host forces redetect, bit self clears
// [R20] D+/D- drive select ignored during BC1.2
// [R21] Fast digital clock while regulator enabled
// [R22] Supply and battery comparators synchronised before use; D+/D- windows and BC1.2 results are not
module cps_sequencer #(
    parameter logic [31:0] P_INTERNAL_REGULATOR_CYC = `CPS_INTERNAL_REGULATOR_CYC,
    parameter logic [31:0] P_QUAL_CYC = `CPS_QUAL_CYC,
    parameter logic [31:0] P_RETRY_CYC = `CPS_RETRY_CYC
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [31:0] o_rd_data,
    input wire logic i_vbus_uvloz,
    input wire logic i_bat_uvloz,
    input wire logic i_vac_present,
    input wire logic i_vac_headroom,
    input wire logic i_vac_sleep,
    input wire logic i_vbus_ov,
    input wire logic i_vbus_min,
    input wire logic i_bat_dpl,
    input wire logic i_bat_ocp,
    input wire logic i_supplement,
    input wire logic i_ship_exit,
    input wire logic i_bc_done,
    input wire logic i_bc_dcp,
    input wire logic i_dcd_timeout,
    input wire logic [2:0] i_dp_window,
    input wire logic [2:0] i_dm_window,
    output logic o_internal_regulator,
    output logic o_fast_clk_sel,
    output logic o_block_switch_on,
    output logic o_battery_switch,
    output logic o_converter_en,
    output logic o_bad_src_load,
    output logic o_bc_run,
    output logic [1:0] o_dplus_drive,
    output logic [1:0] o_dminus_drive,
    output logic [4:0] o_input_current_limit,
    output logic o_host_irq_n
);

    // ****************************************
    // Comparator synchronisers
    // ****************************************
    localparam int NS = 11;
    wire [NS-1:0] raw_w = {i_vbus_uvloz, i_bat_uvloz, i_vac_present, i_vac_headroom, i_vac_sleep,
                           i_vbus_ov, i_vbus_min, i_bat_dpl, i_bat_ocp, i_supplement, i_ship_exit};
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;

    genvar g;
    generate
        for (g = 0; g < NS; g++) begin : g_sync
            always_ff @(posedge i_mclk) begin
                if (i_reset) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= raw_w[g]; // [R22]
                    s2_q[g] <= s1_q[g];
                end
            end
        end
    endgenerate

    wire bus_ok = s2_q[10];
    wire bat_ok = s2_q[9];
    wire present = s2_q[8];
    wire headroom = s2_q[7];
    wire sleep = s2_q[6];
    wire ovp = s2_q[5];
    wire vmin = s2_q[4];
    wire dpl_ok = s2_q[3];
    wire ocp = s2_q[2];
    wire suppl = s2_q[1];
    wire ship_exit = s2_q[0];

    // Held in defaults until either supply clears its UVLO
    wire clr = i_reset | ~(bus_ok | bat_ok); // [R01]

    // ****************************************
    // Register decode
    // ****************************************
    wire wr_ctrl = i_wr_en & (i_addr == `CPS_OFS_CTRL);
    wire wr_ilim = i_wr_en & (i_addr == `CPS_OFS_ILIM);

    // ****************************************
    // Divider classification
    // ****************************************
    wire div1 = i_dp_window[2] & i_dm_window[1];
    wire div2 = i_dp_window[0] & i_dm_window[0];
    wire div3 = i_dp_window[1] & i_dm_window[2];
    wire div4 = i_dp_window[2] & i_dm_window[2];
    wire [4:0] nstd_lim = div1 ? `CPS_ILIM_2A1 : // [R17]
                          div2 ? `CPS_ILIM_2A :
                          div3 ? `CPS_ILIM_1A :
                          div4 ? `CPS_ILIM_2A4 : `CPS_ILIM_500MA; // [R16]
    wire [2:0] nstd_type = (div1 | div2 | div3 | div4) ? `CPS_SRC_NSTD : `CPS_SRC_UNKNOWN;
    wire [4:0] bc_lim = i_bc_dcp ? `CPS_ILIM_2A4 : `CPS_ILIM_500MA; // [R16]
    wire [2:0] bc_type = i_bc_dcp ? `CPS_SRC_DCP : `CPS_SRC_SDP;

    // ****************************************
    // Sequencer state
    // ****************************************
    cps_pkg::cps_state_t st_q;
    cps_pkg::cps_state_t st_d;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic force_q;
    logic host_q;
    logic [1:0] dp_q;
    logic [1:0] dm_q;
    logic [4:0] ilim_q;
    logic good_q;
    logic pg_q;
    logic [2:0] type_q;
    logic bsd_q;
    logic qual_pass;
    logic det_done;
    logic [4:0] det_lim;
    logic [2:0] det_type;

    wire drop = (st_q != cps_pkg::ST_HIZ) & ~present;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 32'h1;
        qual_pass = 1'b0;
        det_done = 1'b0;
        det_lim = ilim_q;
        det_type = type_q;
        unique case (st_q)
            cps_pkg::ST_HIZ: begin
                if (!(present && headroom)) begin
                    cnt_d = 32'h0;
                end else if (cnt_q >= P_INTERNAL_REGULATOR_CYC - 32'h1) begin // [R07]
                    st_d = cps_pkg::ST_QUAL; // [R05]
                    cnt_d = 32'h0;
                end
            end
            cps_pkg::ST_QUAL: begin
                if (ovp || !vmin) begin // [R10]
                    st_d = cps_pkg::ST_RETRY;
                    cnt_d = 32'h0;
                end else if (cnt_q >= P_QUAL_CYC - 32'h1) begin // [R10]
                    st_d = cps_pkg::ST_DETECT; // [R12]
                    cnt_d = 32'h0;
                    qual_pass = 1'b1;
                end
            end
            cps_pkg::ST_RETRY: begin
                if (cnt_q >= P_RETRY_CYC - 32'h1) begin // [R11]
                    st_d = cps_pkg::ST_QUAL;
                    cnt_d = 32'h0;
                end
            end
            cps_pkg::ST_DETECT: begin
                cnt_d = 32'h0;
                if (i_dcd_timeout) begin
                    st_d = cps_pkg::ST_NSTD; // [R15]
                end else if (i_bc_done) begin
                    st_d = cps_pkg::ST_VLIM;
                    det_done = 1'b1;
                    det_lim = bc_lim;
                    det_type = bc_type;
                end
            end
            cps_pkg::ST_NSTD: begin
                cnt_d = 32'h0;
                st_d = cps_pkg::ST_VLIM;
                det_done = 1'b1;
                det_lim = nstd_lim;
                det_type = nstd_type;
            end
            cps_pkg::ST_VLIM: begin
                cnt_d = 32'h0;
                st_d = cps_pkg::ST_RUN;
            end
            cps_pkg::ST_RUN: begin
                cnt_d = 32'h0;
                if (force_q) begin
                    st_d = cps_pkg::ST_DETECT; // [R19]
                end
            end
            default: begin
                cnt_d = 32'h0;
                st_d = cps_pkg::ST_HIZ;
            end
        endcase
        if (drop) begin
            st_d = cps_pkg::ST_HIZ;
            cnt_d = 32'h0;
            qual_pass = 1'b0;
            det_done = 1'b0;
        end
    end

    // ****************************************
    // Next values of control and status
    // ****************************************
    wire attach = (st_q == cps_pkg::ST_HIZ) & (st_d == cps_pkg::ST_QUAL);
    wire force_d = wr_ctrl ? (i_wr_data[`CPS_CTRL_FORCE] & host_q) : (force_q & ~det_done); // [R19]
    wire host_d = wr_ctrl ? i_wr_data[`CPS_CTRL_HOST] : host_q;
    wire [1:0] dp_d = wr_ctrl ? i_wr_data[`CPS_CTRL_DP_LO +: 2] : dp_q;
    wire [1:0] dm_d = wr_ctrl ? i_wr_data[`CPS_CTRL_DM_LO +: 2] : dm_q;
    wire [4:0] ilim_d = wr_ilim ? i_wr_data[4:0] : (det_done ? det_lim : ilim_q); // [R18]
    wire good_d = qual_pass | (good_q & ~drop); // [R12]
    wire pg_d = det_done | (pg_q & ~drop); // [R14]
    wire [2:0] type_d = det_done ? det_type : (drop ? `CPS_SRC_NONE : type_q); // [R14]
    wire bsd_d = (ocp & suppl) | (bsd_q & ~(attach | ship_exit)); // [R03] [R04]
    wire on_d = st_d != cps_pkg::ST_HIZ; // [R08]
    wire run_d = st_d == cps_pkg::ST_RUN;
    wire bc_d = (st_d == cps_pkg::ST_DETECT) & good_d & on_d; // [R13]

    wire [31:0] rd_mux = (i_addr == `CPS_OFS_CTRL) ? {26'h0, dm_q, dp_q, host_q, force_q} :
                         (i_addr == `CPS_OFS_ILIM) ? {27'h0, ilim_q} :
                         (i_addr == `CPS_OFS_STAT) ? {23'h0, st_q, bsd_q, type_q, pg_q, good_q} :
                         32'h0;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (clr) begin
            st_q <= cps_pkg::ST_HIZ;
            cnt_q <= 32'h0;
            force_q <= 1'b0;
            host_q <= 1'b0;
            dp_q <= `CPS_DRV_HIZ;
            dm_q <= `CPS_DRV_HIZ;
            ilim_q <= `CPS_ILIM_RST;
            good_q <= 1'b0;
            pg_q <= 1'b0;
            type_q <= `CPS_SRC_NONE;
            bsd_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            force_q <= force_d;
            host_q <= host_d;
            dp_q <= dp_d;
            dm_q <= dm_d;
            ilim_q <= ilim_d;
            good_q <= good_d;
            pg_q <= pg_d;
            type_q <= type_d;
            bsd_q <= bsd_d;
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (clr) begin
            o_rd_data <= 32'h0;
            o_internal_regulator <= 1'b0;
            o_fast_clk_sel <= 1'b0;
            o_block_switch_on <= 1'b0;
            o_battery_switch <= 1'b0;
            o_converter_en <= 1'b0;
            o_bad_src_load <= 1'b0;
            o_bc_run <= 1'b0;
            o_dplus_drive <= `CPS_DRV_HIZ;
            o_dminus_drive <= `CPS_DRV_HIZ;
            o_input_current_limit <= `CPS_ILIM_RST;
            o_host_irq_n <= 1'b1;
        end else begin
            o_rd_data <= i_rd_en ? rd_mux : 32'h0;
            o_internal_regulator <= on_d; // [R02] [R07] [R08]
            o_fast_clk_sel <= on_d; // [R21]
            o_block_switch_on <= on_d; // [R08]
            o_battery_switch <= dpl_ok & ~bsd_d; // [R02] [R03] [R04]
            o_converter_en <= run_d & ~sleep; // [R06] [R09]
            o_bad_src_load <= st_d == cps_pkg::ST_QUAL; // [R10]
            o_bc_run <= bc_d; // [R13] [R15]
            o_dplus_drive <= bc_d ? `CPS_DRV_HIZ : dp_d; // [R20]
            o_dminus_drive <= bc_d ? `CPS_DRV_HIZ : dm_d; // [R20]
            o_input_current_limit <= ilim_d; // [R18]
            o_host_irq_n <= ~(qual_pass | det_done); // [R12] [R14]
        end
    end

endmodule

// ===== verif/cps_adaptor_model.sv
`timescale 1ns/1ps
// *******
// Adaptor seen through the detection comparators
// *******
module cps_adaptor_model (
    input wire logic i_mclk,
    input wire logic i_bc_run,
    input wire logic [1:0] i_mode,
    input wire logic [3:0] i_delay,
    output logic o_bc_done,
    output logic o_bc_dcp,
    output logic o_dcd_timeout
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic answer;

    assign cnt_d = i_bc_run ? cnt_q + 4'h1 : 4'h0;
    assign answer = i_bc_run && cnt_q >= i_delay;
    assign o_bc_done = answer && i_mode != 2'h2;
    // Result line toggles while detection runs and no answer is given
    assign o_bc_dcp = o_bc_done ? i_mode == 2'h1 : cnt_q[0];
    assign o_dcd_timeout = answer && i_mode == 2'h2;

    always_ff @(posedge i_mclk) begin
        cnt_q <= cnt_d;
    end
endmodule

// ===== verif/cps_seq_properties.sv
`timescale 1ns/1ps
// *******
// Port checks
// *******
module cps_seq_properties (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_vac_present,
    input wire logic o_internal_regulator,
    input wire logic o_fast_clk_sel,
    input wire logic o_block_switch_on,
    input wire logic o_converter_en,
    input wire logic o_bad_src_load,
    input wire logic o_bc_run,
    input wire logic [1:0] o_dplus_drive,
    input wire logic [1:0] o_dminus_drive,
    input wire logic o_host_irq_n
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    AST_DRV_IGNORED: assert property (o_bc_run |-> o_dplus_drive == 2'h0 && o_dminus_drive == 2'h0)
        else $error("drive during detect");
    AST_DET_REG: assert property (o_bc_run |-> o_internal_regulator)
        else $error("detect without regulator");
    AST_HIZ_OFF: assert property (!o_internal_regulator |-> !o_block_switch_on && !o_converter_en)
        else $error("switch on in hiz");
    AST_CLK_SEL: assert property (o_fast_clk_sel == o_internal_regulator)
        else $error("clock select");
    AST_IRQ_PULSE: assert property ($fell(o_host_irq_n) |=> o_host_irq_n)
        else $error("irq width");
    AST_LOAD: assert property (o_bad_src_load |-> o_internal_regulator && !o_bc_run && !o_converter_en)
        else $error("load misplaced");
    AST_CONV: assert property (o_converter_en |-> o_internal_regulator && !o_bc_run && !o_bad_src_load)
        else $error("converter early");
    AST_REG_RISE: assert property ($rose(o_internal_regulator) |-> $past(i_vac_present, 4))
        else $error("regulator early");
    AST_LOSS: assert property ($fell(i_vac_present) |-> ##[1:6] !o_internal_regulator)
        else $error("regulator kept");

    COV_DET: cover property (o_bc_run ##1 !o_bc_run);
    COV_RUN: cover property ($rose(o_converter_en));
    COV_IRQ: cover property ($fell(o_host_irq_n));
endmodule

bind cps_sequencer cps_seq_properties i_cps_seq_properties (.*);

// ===== verif/tb_cps_sequencer.sv
`timescale 1ns/1ps
`include "cps_params.svh"
module tb_cps_sequencer;
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic i_wr_en = 1'b0, i_rd_en = 1'b0, i_vbus_uvloz = 1'b1, i_bat_uvloz = 1'b1;
    logic i_vac_present = 1'b0, i_vac_headroom = 1'b1, i_vac_sleep = 1'b0, i_vbus_ov = 1'b0;
    logic i_vbus_min = 1'b0, i_bat_dpl = 1'b1, i_bat_ocp = 1'b0, i_supplement = 1'b0, i_ship_exit = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wr_data = 32'h0, d, o_rd_data;
    logic [2:0] i_dp_window = 3'h0, i_dm_window = 3'h0;
    logic [1:0] mode = 2'h0, o_dplus_drive, o_dminus_drive;
    logic [3:0] dly = 4'h2;
    logic i_bc_done, i_bc_dcp, i_dcd_timeout, o_internal_regulator, o_fast_clk_sel, o_block_switch_on;
    logic o_battery_switch, o_converter_en, o_bad_src_load, o_bc_run, o_host_irq_n;
    logic [4:0] o_input_current_limit;
    int n_fail = 0, n_tests = 0, n;
    // Per case: mode, D+ window, D- window, limit code, source type
    logic [15:0] tab [7] = '{16'h0029, 16'h802d, 16'h40c3, 16'ha2ae, 16'h89a6, 16'h9456, 16'ha4c6};

    // *******
    // Design and adaptor
    // *******
    cps_sequencer #(.P_INTERNAL_REGULATOR_CYC(32'h14), .P_QUAL_CYC(32'h0a), .P_RETRY_CYC(32'h1e)) i_cps_sequencer (.*);
    cps_adaptor_model i_cps_adaptor_model (.i_mclk(i_mclk), .i_bc_run(o_bc_run), .i_mode(mode),
        .i_delay(dly), .o_bc_done(i_bc_done), .o_bc_dcp(i_bc_dcp), .o_dcd_timeout(i_dcd_timeout));

    always #2.5 i_mclk = ~i_mclk;

    task automatic final_report;
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick;
        @(posedge i_mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_mclk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wr_data <= v;
        @(posedge i_mclk);
        i_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_mclk);
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd_en <= 1'b0;
        #1 v = o_rd_data;
    endtask

    task automatic wait_irq(output int k);
        k = 0;
        while (o_host_irq_n !== 1'b0 && k < 999) begin
            tick();
            k++;
        end
        chk("irq", k < 999, 1'b1);
    endtask

    initial begin
        #50000;
        n_fail++;
        final_report;
    end

    initial begin
        repeat (6) @(posedge i_mclk);
        i_reset <= 1'b0;
        repeat (4) tick();
        rd(`CPS_OFS_ILIM, d);
        chk("ilim_rst", d, 32'h5);
        rd(8'h0c, d);
        chk("unmapped", d, 32'h0);
        chk("bat_only", {o_battery_switch, o_internal_regulator}, 2'h2);
        i_supplement <= 1'b1;
        i_bat_ocp <= 1'b1;
        repeat (4) tick();
        i_bat_ocp <= 1'b0;
        rd(`CPS_OFS_STAT, d);
        chk("bsw_dis", {d[5], o_battery_switch}, 2'h2);
        repeat (4) tick();
        chk("bsw_held", o_battery_switch, 1'b0);
        i_ship_exit <= 1'b1;
        repeat (4) tick();
        i_ship_exit <= 1'b0;
        chk("bsw_ship", o_battery_switch, 1'b1);
        // Short attach glitch must restart the stability count
        i_vac_present <= 1'b1;
        repeat (10) tick();
        i_vac_present <= 1'b0;
        repeat (3) tick();
        i_vac_present <= 1'b1;
        n = 0;
        while (o_internal_regulator !== 1'b1 && n < 99) begin
            tick();
            n++;
        end
        chk("internal_regulator_delay", n >= 20 && n <= 26, 1'b1);
        chk("load", o_bad_src_load, 1'b1);
        repeat (3) tick();
        rd(`CPS_OFS_STAT, d);
        chk("retry", d[8:6], 3'h2);
        i_vbus_min <= 1'b1;
        wait_irq(n);
        chk("retry_span", n >= 20 && n <= 60, 1'b1);
        chk("bc_run", o_bc_run, 1'b1);
        for (int i = 0; i < 7; i++) begin
            tick();
            mode <= tab[i][15:14];
            i_dp_window <= tab[i][13:11];
            i_dm_window <= tab[i][10:8];
            dly <= 4'(2 * i + 2);
            // Host mode must already be set before a force write is taken
            if (i == 1) wr(`CPS_OFS_CTRL, 32'h2);
            if (i > 0) wr(`CPS_OFS_CTRL, 32'h3);
            wait_irq(n);
            repeat (2) tick();
            chk("ilim", o_input_current_limit, tab[i][7:3]);
            chk("conv", o_converter_en, 1'b1);
            rd(`CPS_OFS_STAT, d);
            chk("stat", d[4:0], {tab[i][2:0], 2'h3});
            rd(`CPS_OFS_CTRL, d);
            chk("force", d[0], 1'b0);
        end
        wr(`CPS_OFS_ILIM, 32'h7);
        repeat (2) tick();
        chk("ilim_host", o_input_current_limit, 5'h07);
        wr(`CPS_OFS_CTRL, 32'h3a);
        repeat (2) tick();
        chk("drv", {o_dplus_drive, o_dminus_drive}, 4'hb);
        wr(`CPS_OFS_CTRL, 32'h3b);
        wait_irq(n);
        tick();
        rd(`CPS_OFS_CTRL, d);
        chk("force_clr", d, 32'h3a);
        i_vac_sleep <= 1'b1;
        repeat (5) tick();
        chk("sleep", o_converter_en, 1'b0);
        i_vac_sleep <= 1'b0;
        repeat (5) tick();
        chk("wake", o_converter_en, 1'b1);
        i_vac_present <= 1'b0;
        repeat (5) tick();
        chk("hiz", {o_internal_regulator, o_block_switch_on, o_converter_en}, 3'h0);
        chk("slow_clk", o_fast_clk_sel, 1'b0);
        rd(`CPS_OFS_STAT, d);
        chk("hiz_stat", d, 32'h0);
        wr(`CPS_OFS_ILIM, 32'h7);
        i_vbus_uvloz <= 1'b0;
        i_bat_uvloz <= 1'b0;
        repeat (4) tick();
        i_vbus_uvloz <= 1'b1;
        i_bat_uvloz <= 1'b1;
        repeat (4) tick();
        rd(`CPS_OFS_ILIM, d);
        chk("por", d, 32'h5);
        final_report;
    end
endmodule
